// [cod_table.sv]
`timescale 1ns/10ps
`default_nettype none

// Pure lookup of length, cycle count and class for one opcode.
module cod_table
(
   // Opcode under decode.
   input  wire logic [7:0]        opc,
   // Decoded attributes.
   output logic [1:0]             len,
   output logic [3:0]             cyc,
   output cod_pkg::cod_cls_t      cls
);

   // Lower nibble and upper nibble split out for the grouped decode.
   logic [3:0] hi;
   logic [3:0] lo;
   assign hi = opc[7:4];
   assign lo = opc[3:0];

   // Main decode; every opcode yields a defined answer.
   always_comb
   begin
      len = cod_pkg::COD_LEN1;
      cyc = cod_pkg::COD_CYC2;
      cls = cod_pkg::COD_CLS_MISC;
      if (lo == 4'h1)
      begin
         // Absolute jump on even upper bit four, call on odd.
         len = cod_pkg::COD_LEN2;
         cyc = cod_pkg::COD_CYC4;
         cls = cod_pkg::COD_CLS_BRANCH;
      end
      else if (lo >= 4'h4 && opc != 8'ha4 && opc != 8'h84 &&
               opc != 8'hc4 && opc != 8'hd4 && opc != 8'he4 &&
               opc != 8'hf4 && opc != 8'ha5 && opc != 8'hb4 &&
               opc != 8'hb5 && opc != 8'hd5 && opc != 8'h85)
      begin
         // Regular operand-mode columns: 4 imm/A, 5 dir, 6-7 @Ri, 8-F Rn.
         len = (lo == 4'h4 || lo == 4'h5) ? cod_pkg::COD_LEN2
                                          : cod_pkg::COD_LEN1;
         cyc = cod_pkg::COD_CYC2;
         case (hi)
            4'h0, 4'h1:
            begin
               cls = cod_pkg::COD_CLS_ARITH;
               if (lo == 4'h4)
                  len = cod_pkg::COD_LEN1;
            end
            4'h2, 4'h3, 4'h9:
               cls = cod_pkg::COD_CLS_ARITH;
            4'h4, 4'h5, 4'h6:
               cls = cod_pkg::COD_CLS_LOGIC;
            4'h7:
            begin
               // Immediate moves to A, direct, @Ri and Rn.
               cls = cod_pkg::COD_CLS_XFER;
               if (lo == 4'h5)
               begin
                  len = cod_pkg::COD_LEN3;
                  cyc = cod_pkg::COD_CYC4;
               end
               else if (lo != 4'h4)
                  len = cod_pkg::COD_LEN2;
            end
            4'h8, 4'ha:
            begin
               // Moves between direct and register/indirect memory.
               cls = cod_pkg::COD_CLS_XFER;
               cyc = cod_pkg::COD_CYC4;
               len = cod_pkg::COD_LEN2;
            end
            4'hb:
            begin
               // Compare and branch on register or indirect operand.
               cls = cod_pkg::COD_CLS_BRANCH;
               cyc = cod_pkg::COD_CYC4;
               len = cod_pkg::COD_LEN3;
            end
            4'hc, 4'he, 4'hf:
               cls = cod_pkg::COD_CLS_XFER;
            4'hd:
            begin
               if (lo >= 4'h8)
               begin
                  cls = cod_pkg::COD_CLS_BRANCH;
                  cyc = cod_pkg::COD_CYC4;
                  len = cod_pkg::COD_LEN2;
               end
               else
                  cls = cod_pkg::COD_CLS_XFER;
            end
            default:
               cls = cod_pkg::COD_CLS_MISC;
         endcase
      end
      else
      begin
         // Irregular opcodes listed one by one.
         case (opc)
            8'h00, 8'ha5:
               cls = cod_pkg::COD_CLS_MISC;
            8'ha3:
            begin
               cyc = cod_pkg::COD_CYC4;
               cls = cod_pkg::COD_CLS_ARITH;
            end
            8'ha4, 8'h84:
            begin
               cyc = cod_pkg::COD_CYC8;
               cls = cod_pkg::COD_CLS_ARITH;
            end
            8'hd4:
               cls = cod_pkg::COD_CLS_ARITH;
            8'h52, 8'h42, 8'h62:
            begin
               len = cod_pkg::COD_LEN2;
               cls = cod_pkg::COD_CLS_LOGIC;
            end
            8'h53, 8'h43, 8'h63:
            begin
               len = cod_pkg::COD_LEN3;
               cyc = cod_pkg::COD_CYC4;
               cls = cod_pkg::COD_CLS_LOGIC;
            end
            8'he4, 8'hf4, 8'hc4, 8'h23, 8'h33, 8'h03, 8'h13:
               cls = cod_pkg::COD_CLS_LOGIC;
            8'h85:
            begin
               len = cod_pkg::COD_LEN3;
               cyc = cod_pkg::COD_CYC4;
               cls = cod_pkg::COD_CLS_XFER;
            end
            8'h90:
            begin
               len = cod_pkg::COD_LEN3;
               cyc = cod_pkg::COD_CYC4;
               cls = cod_pkg::COD_CLS_XFER;
            end
            8'h93, 8'h83, 8'he0, 8'hf0, 8'he2, 8'he3, 8'hf2, 8'hf3:
            begin
               cyc = cod_pkg::COD_CYC4;
               cls = cod_pkg::COD_CLS_XFER;
            end
            8'hc0, 8'hd0:
            begin
               len = cod_pkg::COD_LEN2;
               cyc = cod_pkg::COD_CYC4;
               cls = cod_pkg::COD_CLS_XFER;
            end
            8'hc3, 8'hd3, 8'hb3:
               cls = cod_pkg::COD_CLS_BOOL;
            8'hc2, 8'hd2, 8'hb2, 8'ha2:
            begin
               len = cod_pkg::COD_LEN2;
               cls = cod_pkg::COD_CLS_BOOL;
            end
            8'h82, 8'hb0, 8'h72, 8'ha0, 8'h92:
            begin
               len = cod_pkg::COD_LEN2;
               cyc = cod_pkg::COD_CYC4;
               cls = cod_pkg::COD_CLS_BOOL;
            end
            8'h12, 8'h02, 8'hb4, 8'hb5, 8'hd5, 8'h20, 8'h30, 8'h10:
            begin
               len = cod_pkg::COD_LEN3;
               cyc = cod_pkg::COD_CYC4;
               cls = cod_pkg::COD_CLS_BRANCH;
            end
            8'h22, 8'h32, 8'h73:
            begin
               cyc = cod_pkg::COD_CYC4;
               cls = cod_pkg::COD_CLS_BRANCH;
            end
            8'h80, 8'h40, 8'h50, 8'h60, 8'h70:
            begin
               len = cod_pkg::COD_LEN2;
               cyc = cod_pkg::COD_CYC4;
               cls = cod_pkg::COD_CLS_BRANCH;
            end
            default:
               cls = cod_pkg::COD_CLS_MISC;
         endcase
      end
   end

endmodule

`default_nettype wire

// [cod_pkg.sv]
package cod_pkg;

   // Operation classes reported with each decoded opcode.
   typedef enum logic [2:0] {
      COD_CLS_MISC,
      COD_CLS_ARITH,
      COD_CLS_LOGIC,
      COD_CLS_XFER,
      COD_CLS_BOOL,
      COD_CLS_BRANCH
   } cod_cls_t;

   // Instruction lengths in bytes.
   localparam logic [1:0] COD_LEN1 = 2'h1;
   localparam logic [1:0] COD_LEN2 = 2'h2;
   localparam logic [1:0] COD_LEN3 = 2'h3;

   // Execution times in system clock cycles.
   localparam logic [3:0] COD_CYC2 = 4'h2;
   localparam logic [3:0] COD_CYC4 = 4'h4;
   localparam logic [3:0] COD_CYC8 = 4'h8;

   // Field positions inside an opcode byte.
   localparam int COD_REG_LSB  = 0;
   localparam int COD_PAGE_LSB = 5;

   // Values after reset.
   localparam logic [7:0] COD_OPC_RST  = 8'h00;
   localparam logic [3:0] COD_CNT_RST  = 4'h0;

endpackage

// [cod_cycle_cnt.sv]
`timescale 1ns/10ps
`default_nettype none

// Down counter that holds an instruction for its cycle count.
module cod_cycle_cnt
#(
   parameter int W = 4
)
(
   // Clock and reset.
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   // Load of a new count.
   input  wire logic          load,
   input  wire logic [W-1:0]  val,
   // Remaining cycles, zero when idle.
   output logic [W-1:0]       cnt_q
);

   // Refuse widths too narrow for the longest instruction at elaboration,
   // so a bad width never reaches a run.
   if (W < 4)
   begin : g_bad_width
      $error("cod_cycle_cnt: width too small");
   end

   // Load wins over the running count; count stops at zero.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         cnt_q <= W'(cod_pkg::COD_CNT_RST);
      else if (load)
         cnt_q <= val;
      else if (cnt_q != '0)
         cnt_q <= cnt_q - W'(1);
   end

endmodule

`default_nettype wire

// [cod_decode.sv]
`timescale 1ns/10ps
`default_nettype none

// Decoder front end: accepts an opcode when idle, reports its attributes
// in registers and holds busy for exactly the instruction's cycle count.
module cod_decode
(
   // Clock and reset.
   input  wire logic                 ref_clk,
   input  wire logic                 rstn,
   // Opcode offered by the fetch unit.
   input  wire logic                 opc_valid,
   input  wire logic [7:0]           opc,
   // Decoded instruction; take and done are one-cycle pulses, the attributes are held for the whole execution.
   output logic                      opc_taken_q,
   output logic                      busy_q,
   output logic                      done_q,
   output logic [7:0]                opc_q,
   output logic [1:0]                len_q,
   output logic [3:0]                cyc_q,
   output cod_pkg::cod_cls_t         cls_q,
   output logic [2:0]                reg_idx_q,
   output logic                      reg_grp_q,
   output logic [2:0]                page_q,
   output logic                      abs_call_q,
   output logic                      abs_jump_q
);

   // Combinational attributes of the offered opcode.
   logic [1:0]        len_d;
   logic [3:0]        cyc_d;
   cod_pkg::cod_cls_t cls_d;
   logic              take;
   logic [3:0]        cnt;

   // Execution states.
   typedef enum logic [0:0] {
      COD_IDLE,
      COD_RUN
   } cod_st_t;
   cod_st_t st_q;

   // Lookup table shared by all opcodes.
   cod_table u_table
   (
      .opc (opc),
      .len (len_d),
      .cyc (cyc_d),
      .cls (cls_d)
   );

   // An opcode is taken when idle, or on the last cycle of the current one,
   // so back-to-back instructions run with no gap.
   assign take = opc_valid && (st_q == COD_IDLE || cnt == 4'h1);

   // Remaining-cycle counter, loaded with the full count on take.
   cod_cycle_cnt #(.W(4)) u_cnt
   (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .load    (take),
      .val     (cyc_d),
      .cnt_q   (cnt)
   );

   // State: running while the counter has cycles left.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         st_q <= COD_IDLE;
      else
      begin
         case (st_q)
            COD_IDLE:
               if (take)
                  st_q <= COD_RUN;
            COD_RUN:
               if (cnt == 4'h1 && !take)
                  st_q <= COD_IDLE;
            default:
               st_q <= COD_IDLE;
         endcase
      end
   end

   // Busy mirrors the run state; done pulses as the last cycle ends.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         busy_q      <= 1'b0;
         done_q      <= 1'b0;
         opc_taken_q <= 1'b0;
      end
      else
      begin
         busy_q      <= take || (st_q == COD_RUN && cnt != 4'h1);
         done_q      <= st_q == COD_RUN && cnt == 4'h1;
         opc_taken_q <= take;
      end
   end

   // Attribute registers, captured once per taken opcode.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         opc_q <= cod_pkg::COD_OPC_RST;
         len_q <= cod_pkg::COD_LEN1;
         cyc_q <= cod_pkg::COD_CYC2;
         cls_q <= cod_pkg::COD_CLS_MISC;
      end
      else if (take)
      begin
         opc_q <= opc;
         len_q <= len_d;
         cyc_q <= cyc_d;
         cls_q <= cls_d;
      end
   end

   // Working register select for the eight-wide groups (column 8-F).
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         reg_idx_q <= 3'h0;
         reg_grp_q <= 1'b0;
      end
      else if (take)
      begin
         reg_idx_q <= opc[cod_pkg::COD_REG_LSB +: 3];
         // Bit three marks the eight-wide register column.
         reg_grp_q <= opc[3];
      end
   end

   // Absolute jumps and calls carry target bits 10..8 in the opcode.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         page_q     <= 3'h0;
         abs_call_q <= 1'b0;
         abs_jump_q <= 1'b0;
      end
      else if (take)
      begin
         page_q     <= opc[cod_pkg::COD_PAGE_LSB +: 3];
         abs_call_q <= opc[3:0] == 4'h1 && opc[4];
         abs_jump_q <= opc[3:0] == 4'h1 && !opc[4];
      end
   end

endmodule

`default_nettype wire

// [cod_decode_monitor.sv]
`timescale 1ns/10ps
`default_nettype none

// Port-level checks of decode attributes and instruction timing.
module cod_decode_monitor
(
   // Clock and reset.
   input wire logic              ref_clk,
   input wire logic              rstn,
   // Fetch side.
   input wire logic              opc_valid,
   input wire logic [7:0]        opc,
   // Decoded instruction.
   input wire logic              opc_taken_q,
   input wire logic              busy_q,
   input wire logic              done_q,
   input wire logic [7:0]        opc_q,
   input wire logic [1:0]        len_q,
   input wire logic [3:0]        cyc_q,
   input wire cod_pkg::cod_cls_t cls_q,
   input wire logic [2:0]        reg_idx_q,
   input wire logic              reg_grp_q,
   input wire logic [2:0]        page_q,
   input wire logic              abs_call_q,
   input wire logic              abs_jump_q
);
   // One clock domain, so clock and reset are given once.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   a_idle_take: assert property (
      opc_valid && !busy_q |=> opc_taken_q && opc_q == $past(opc))
      else $error("opcode offered while idle was not taken");
   // Done also pulses when the next opcode is taken in the same edge, so
   // busy may stay high then, but only together with a fresh take.
   a_done_pulse: assert property (
      done_q |-> $past(busy_q) && (!busy_q || opc_taken_q) ##1 !done_q)
      else $error("done pulse out of place");
   a_gap_two: assert property (
      opc_taken_q && cyc_q == 4'h2 |=>
      busy_q && !opc_taken_q ##1 (opc_taken_q || done_q))
      else $error("two-cycle instruction ran wrong length");
   a_gap_four: assert property (
      opc_taken_q && cyc_q == 4'h4 |=>
      (busy_q && !opc_taken_q)[*3] ##1 (opc_taken_q || done_q))
      else $error("four-cycle instruction ran wrong length");
   a_gap_eight: assert property (
      opc_taken_q && (opc_q == 8'ha4 || opc_q == 8'h84) |-> cyc_q == 4'h8
      ##1 (busy_q && !opc_taken_q)[*7] ##1 (opc_taken_q || done_q))
      else $error("multiply or divide ran wrong length");
   a_reg_fields: assert property (
      opc_taken_q |-> reg_idx_q == opc_q[2:0] && reg_grp_q == opc_q[3]
      && page_q == opc_q[7:5])
      else $error("register or page field wrong");
   a_abs_flags: assert property (
      opc_taken_q && opc_q[3:0] == 4'h1 |-> abs_call_q == opc_q[4] &&
      abs_jump_q != opc_q[4] && len_q == 2'h2 && cyc_q == 4'h4)
      else $error("absolute call or jump decoded wrong");
   a_long_ctl: assert property (
      opc_taken_q && opc_q[3:0] == 4'h2 && opc_q[7:5] == 3'h0 |->
      len_q == 2'h3 && cyc_q == 4'h4)
      else $error("long call or jump decoded wrong");
   a_unlisted_nop: assert property (
      opc_taken_q && opc_q == 8'ha5 |->
      cyc_q == 4'h2 && cls_q == cod_pkg::COD_CLS_MISC)
      else $error("unlisted opcode not run as no-op");
endmodule

bind cod_decode cod_decode_monitor u_cod_decode_monitor (
   .ref_clk(ref_clk), .rstn(rstn), .opc_valid(opc_valid), .opc(opc),
   .opc_taken_q(opc_taken_q), .busy_q(busy_q), .done_q(done_q),
   .opc_q(opc_q), .len_q(len_q), .cyc_q(cyc_q), .cls_q(cls_q),
   .reg_idx_q(reg_idx_q), .reg_grp_q(reg_grp_q), .page_q(page_q),
   .abs_call_q(abs_call_q), .abs_jump_q(abs_jump_q));
`default_nettype wire

// [cod_fetch_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Program memory with fetch: offers opcodes in order and moves on only
// after the decoder reports a take.
module cod_fetch_model
#(
   parameter int PN = 4
)
(
   // Clock and reset.
   input  wire logic            ref_clk,
   input  wire logic            rstn,
   // Bench control and program image.
   input  wire logic            run,
   input  wire logic [8*PN-1:0] code,
   // Decoder handshake.
   input  wire logic            opc_taken_q,
   output logic                 opc_valid,
   output logic [7:0]           opc
);
   int pc_q; // Index of the opcode on offer.

   // Step on the take report; a take is never possible in that cycle.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         pc_q <= 0;
      end
      else if (opc_taken_q)
      begin
         pc_q <= pc_q + 1;
      end
   end

   // When not offering, show the inverse so a stale opcode cannot pass.
   assign opc_valid = run && (pc_q < PN);
   assign opc = opc_valid ? code[8*(pc_q % PN) +: 8]
                          : ~code[8*(pc_q % PN) +: 8];
endmodule
`default_nettype wire

// [cpu_opcode_decode_timing_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module cpu_opcode_decode_timing_tb_top;
   localparam int NT = 86;
   // Entries: opcode, bytes, cycles, class code.
   localparam logic [19:0] TBL [NT] = '{
      20'ha4181, 20'h84181, 20'hd4121, 20'ha3141,
      20'h24221, 20'h25221, 20'h26121, 20'h2f121,
      20'h34221, 20'h3a121, 20'h95221, 20'h97121,
      20'h04121, 20'h0f121, 20'h15221, 20'h16121,
      20'h53342, 20'h43342, 20'h63342, 20'h52222,
      20'h42222, 20'h62222, 20'h58122, 20'h4f122,
      20'h6c122, 20'h54222, 20'he4122, 20'hf4122,
      20'h23122, 20'h33122, 20'h03122, 20'h13122,
      20'hc4122, 20'ha8243, 20'h8f243, 20'h85343,
      20'h86243, 20'h75343, 20'he8123, 20'h78223,
      20'h90343, 20'h93143, 20'h83143, 20'he2143,
      20'hf3143, 20'he0143, 20'hf0143, 20'hc0243,
      20'hd0243, 20'hc8123, 20'hc5223, 20'hc7123,
      20'hd6123, 20'h82244, 20'hb0244, 20'h72244,
      20'ha0244, 20'hc3124, 20'hd2224, 20'hb3124,
      20'h92244, 20'ha2224, 20'h11245, 20'hf1245,
      20'h01245, 20'he1245, 20'h12345, 20'h02345,
      20'h22145, 20'h32145, 20'h40245, 20'h50245,
      20'h20345, 20'h30345, 20'h10345, 20'h73145,
      20'h60245, 20'h70245, 20'hb5345, 20'hb4345,
      20'hbf345, 20'hb6345, 20'hd8245, 20'hd5345,
      20'h00120, 20'ha5120};
   logic              ref_clk = 1'b0;
   logic              rstn = 1'b0;
   logic              run = 1'b0;
   logic [8*NT-1:0]   prog;
   logic              opc_valid, opc_taken_q, busy_q, done_q;
   logic [7:0]        opc, opc_q;
   logic [1:0]        len_q;
   logic [3:0]        cyc_q;
   cod_pkg::cod_cls_t cls_q;
   logic [2:0]        reg_idx_q, page_q;
   logic              reg_grp_q, abs_call_q, abs_jump_q;
   int                fails = 0;
   int                cmp_count = 0;

   // Clock of 100 ns period.
   always #50 ref_clk = ~ref_clk;

   cod_decode u_cod_decode (.ref_clk(ref_clk), .rstn(rstn),
      .opc_valid(opc_valid), .opc(opc), .opc_taken_q(opc_taken_q),
      .busy_q(busy_q), .done_q(done_q), .opc_q(opc_q), .len_q(len_q),
      .cyc_q(cyc_q), .cls_q(cls_q), .reg_idx_q(reg_idx_q),
      .reg_grp_q(reg_grp_q), .page_q(page_q), .abs_call_q(abs_call_q),
      .abs_jump_q(abs_jump_q));
   cod_fetch_model #(.PN(NT)) u_cod_fetch_model (.ref_clk(ref_clk),
      .rstn(rstn), .run(run), .code(prog), .opc_taken_q(opc_taken_q),
      .opc_valid(opc_valid), .opc(opc));

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Compares one result; narrower values arrive zero-extended.
   task automatic cmp_val(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Waits, bounded, for a take or a done; n counts falling edges.
   task automatic wait_evt(output int n);
      n = 0;
      do
      begin
         @(negedge ref_clk);
         n++;
      end
      while (opc_taken_q !== 1'b1 && done_q !== 1'b1 && n < 40);
   endtask

   // Checks every attribute of table entry i just after its take.
   task automatic check_attr(input int i);
      logic [7:0] o;
      o = TBL[i][19:12];
      cmp_val("taken", 8'h01, {7'h00, opc_taken_q});
      cmp_val("opc", o, opc_q);
      cmp_val("len", {4'h0, TBL[i][11:8]}, {6'h00, len_q});
      cmp_val("cyc", {4'h0, TBL[i][7:4]}, {4'h0, cyc_q});
      cmp_val("cls", {4'h0, TBL[i][3:0]}, {5'h00, cls_q});
      cmp_val("reg", {4'h0, o[3:0]}, {4'h0, reg_grp_q, reg_idx_q});
      cmp_val("page", {5'h00, o[7:5]}, {5'h00, page_q});
      cmp_val("abs", {6'h00, o[4:0] == 5'h11, o[4:0] == 5'h01},
              {6'h00, abs_call_q, abs_jump_q});
   endtask

   // After reset the decoder is idle with its reset defaults.
   task automatic t_reset_vals();
      cmp_val("idle", 8'h00, {6'h00, busy_q, done_q});
      cmp_val("len rst", 8'h01, {6'h00, len_q});
      cmp_val("cyc rst", 8'h02, {4'h0, cyc_q});
      $display("test reset values done");
   endtask

   // A lone multiply: eight busy cycles, then a single done pulse.
   task automatic t_single();
      int n;
      run = 1'b1;
      wait_evt(n);
      run = 1'b0;
      check_attr(0);
      wait_evt(n);
      cmp_val("mul gap", 8'h08, n[7:0]);
      cmp_val("done", 8'h01, {6'h00, busy_q, done_q});
      @(negedge ref_clk);
      cmp_val("done end", 8'h00, {6'h00, busy_q, done_q});
      $display("test single multiply done");
   endtask

   // Table entries 1 onward back to back; offers made while busy must be refused.
   task automatic t_stream();
      int n;
      run = 1'b1;
      wait_evt(n);
      for (int i = 1; i < NT; i++)
      begin
         check_attr(i);
         wait_evt(n);
         cmp_val("gap", {4'h0, TBL[i][7:4]}, n[7:0]);
         cmp_val("end pulse", 8'h01, {7'h00, done_q});
      end
      run = 1'b0;
      cmp_val("last done", 8'h01, {7'h00, done_q});
      $display("test opcode stream done");
   endtask

   // Reset in mid-instruction must drop busy and leave a clean restart.
   task automatic t_mid_reset();
      int n;
      rstn = 1'b0;
      @(negedge ref_clk);
      rstn = 1'b1;
      run = 1'b1;
      wait_evt(n);
      run = 1'b0;
      repeat (3) @(negedge ref_clk);
      rstn = 1'b0;
      @(negedge ref_clk);
      rstn = 1'b1;
      cmp_val("cut", 8'h00, {6'h00, busy_q, done_q});
      t_single();
      $display("test mid-run reset done");
   endtask

   // Main sequence; inputs change only at falling edges.
   initial
   begin
      for (int i = 0; i < NT; i++)
         prog[8*i +: 8] = TBL[i][19:12];
      repeat (2) @(negedge ref_clk);
      rstn = 1'b1;
      t_reset_vals();
      t_single();
      t_stream();
      t_mid_reset();
      wrap_up();
   end

   // The tests need well under a thousand cycles; this cuts a hang.
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      fails++;
      wrap_up();
   end
endmodule
`default_nettype wire
